// *** hw/scci_device.sv ***
// Modem end: serial command interpreter, receive buffer and tone keyer.
// Assumes a radio core on the user side and an external nonvolatile store.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module scci_device
	import scci_pkg::*;
#(
	parameter int BIT_CYC   = BIT_CYCLES,
	parameter int LOW_HALF  = LOW_HALF_CYCLES,
	parameter int HIGH_HALF = HIGH_HALF_CYCLES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	scci_link_if.device            link,
	output logic [NODE_W-1:0]      node_id,
	output logic [SLOT_W-1:0]      radio_slot,
	output logic                   radio_tx_valid,
	output logic [7:0]             radio_tx_data,
	input  wire logic              radio_tx_ready,
	input  wire logic              radio_rx_valid,
	input  wire logic [7:0]        radio_rx_data,
	input  wire logic [NODE_W-1:0] radio_rx_node,
	input  wire logic [SLOT_W-1:0] radio_rx_slot,
	input  wire logic [NODE_W-1:0] nv_dflt_node,
	input  wire logic [SLOT_W-1:0] nv_dflt_slot,
	output logic                   nv_wr_req,
	output logic [NODE_W-1:0]      nv_wr_node,
	output logic [SLOT_W-1:0]      nv_wr_slot,
	input  wire logic              nv_wr_done,
	output logic                   tx_key,
	output logic                   tx_mod,
	output logic                   cfg_mode
);
	logic [1:0]            pin_s1_reg;
	logic [1:0]            pin_s2_reg;
	logic [1:0]            pin_s3_reg;
	logic [1:0]            pin_q_reg;
	logic                  active;
	logic                  rx_valid;
	logic [7:0]            rx_data;
	logic                  tx_busy;
	logic                  tx_start_reg;
	logic [7:0]            tx_byte_reg;
	logic                  echo_pend_reg;
	logic [7:0]            echo_byte_reg;
	logic                  tilde_pend_reg;
	logic                  nv_busy_reg;
	logic [79:0]           line_reg;
	logic [3:0]            len_reg;
	logic                  hold_valid_reg;
	logic [RX_AW:0]        wr_ptr_reg;
	logic [RX_AW:0]        rd_ptr_reg;
	logic [7:0]            rx_mem [RX_DEPTH];
	logic                  status_reg;
	scci_tone_t            tone_reg;
	logic [TONE_CNT_W-1:0] tone_cnt_reg;
	logic                  tone_sq_reg;

	// Setup is bit 0, enable bit 1; both idle high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg <= 2'h3;
			pin_s2_reg <= 2'h3;
			pin_s3_reg <= 2'h3;
			pin_q_reg  <= 2'h3;
		end else begin
			pin_s1_reg <= {link.enable_n, link.setup_n};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			pin_q_reg  <= (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
				| (pin_q_reg & (pin_s2_reg ^ pin_s3_reg));
		end
	end

	assign active   = ~pin_q_reg[1]; // RQ20
	assign cfg_mode = active & ~pin_q_reg[0]; // RQ1 RQ14

	scci_uart #(
		.BIT_CYC(BIT_CYC)
	) u_uart (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rx_pin  (link.host_txd),
		.rx_valid(rx_valid),
		.rx_data (rx_data),
		.tx_start(tx_start_reg),
		.tx_data (tx_byte_reg),
		.tx_busy (tx_busy),
		.tx_pin  (link.dev_rxd)
	);

	wire host_cmd  = rx_valid & cfg_mode;
	wire host_data = rx_valid & active & ~cfg_mode;
	wire line_end  = host_cmd & (rx_data == CH_CR); // RQ13

	wire [7:0] digit    = line_reg[7:0] - CH_ZERO;
	wire       is_digit = line_reg[7:0] >= CH_ZERO;
	wire cmd_node = (len_reg == LEN_NODE) && (line_reg[39:8] == NODE_PREFIX)
		&& is_digit && (line_reg[7:0] <= CH_NODE_MAX); // RQ5
	wire cmd_slot = (len_reg == LEN_NODE) && (line_reg[39:8] == SLOT_PREFIX)
		&& is_digit && (line_reg[7:0] <= CH_SLOT_MAX); // RQ6
	wire cmd_save = (len_reg == LEN_SAVE) && (line_reg == SAVE_TEXT);
	wire tone_len = (len_reg == LEN_TONE);
	wire cmd_carrier = tone_len && (line_reg[47:0] == CARRIER_TEXT);
	wire cmd_low     = tone_len && (line_reg[47:0] == LOW_TEXT);
	wire cmd_high    = tone_len && (line_reg[47:0] == HIGH_TEXT);
	wire cmd_off = (len_reg == LEN_HASH) && (line_reg[7:0] == CH_HASH);

	wire rx_empty = (wr_ptr_reg == rd_ptr_reg);
	wire rx_full  = (wr_ptr_reg[RX_AW] != rd_ptr_reg[RX_AW])
		&& (wr_ptr_reg[RX_AW-1:0] == rd_ptr_reg[RX_AW-1:0]);
	wire rx_flush = ~active | cfg_mode | host_data; // RQ2 RQ22
	wire peer_ok  = (radio_rx_node == node_id)
		&& (radio_rx_slot == radio_slot); // RQ7
	wire rx_accept = radio_rx_valid & peer_ok & ~rx_full & ~rx_flush;

	wire tx_idle    = ~tx_busy & ~tx_start_reg;
	wire send_echo  = tx_idle & echo_pend_reg;
	wire send_tilde = tx_idle & ~echo_pend_reg & tilde_pend_reg;
	wire send_rx    = tx_idle & ~echo_pend_reg & ~tilde_pend_reg
		& ~rx_empty & ~rx_flush;

	assign radio_tx_valid = hold_valid_reg & active & ~cfg_mode; // RQ2
	assign nv_wr_node     = node_id;
	assign nv_wr_slot     = radio_slot;
	assign link.status    = status_reg;

	// The length saturates so an overlong line never aliases a command.
	always_ff @(posedge aclk) begin
		nv_wr_req <= 1'b0;
		if (!aresetn) begin
			line_reg    <= '0;
			len_reg     <= 4'h0;
			node_id     <= nv_dflt_node; // RQ9
			radio_slot  <= nv_dflt_slot; // RQ9
			nv_busy_reg <= 1'b0;
			tone_reg    <= TONE_OFF;
		end else begin
			if (line_end) begin
				line_reg <= '0; // RQ23
				len_reg  <= 4'h0;
				if (cmd_node) begin
					node_id <= digit[NODE_W-1:0]; // RQ8
				end
				if (cmd_slot) begin
					radio_slot <= digit[SLOT_W-1:0]; // RQ8
				end
				if (cmd_save && !nv_busy_reg) begin
					nv_wr_req   <= 1'b1; // RQ10
					nv_busy_reg <= 1'b1;
				end
				if (cmd_carrier) begin
					tone_reg <= TONE_CARRIER; // RQ12
				end
				if (cmd_low) begin
					tone_reg <= TONE_LOW; // RQ12
				end
				if (cmd_high) begin
					tone_reg <= TONE_HIGH; // RQ12
				end
				if (cmd_off) begin
					tone_reg <= TONE_OFF; // RQ12
				end
			end else if (host_cmd) begin
				line_reg <= {line_reg[71:0], rx_data}; // RQ4
				if (len_reg != LEN_SAT) begin
					len_reg <= len_reg + 4'h1;
				end
			end
			if (nv_wr_done && nv_busy_reg) begin
				nv_busy_reg <= 1'b0;
			end
			// Tones are setup-only.
			if (!cfg_mode) begin
				tone_reg <= TONE_OFF;
			end
		end
	end

	// Serial output arbitration: echo first, then the tilde, then data.
	always_ff @(posedge aclk) begin
		tx_start_reg <= 1'b0;
		if (!aresetn) begin
			tx_byte_reg    <= 8'h00;
			echo_pend_reg  <= 1'b0;
			echo_byte_reg  <= 8'h00;
			tilde_pend_reg <= 1'b0;
		end else begin
			if (host_cmd) begin
				echo_pend_reg <= 1'b1; // RQ3
				echo_byte_reg <= rx_data;
			end else if (send_echo) begin
				echo_pend_reg <= 1'b0;
			end
			if (nv_wr_done && nv_busy_reg) begin
				tilde_pend_reg <= 1'b1; // RQ11
			end else if (send_tilde) begin
				tilde_pend_reg <= 1'b0;
			end
			if (send_echo) begin
				tx_start_reg <= 1'b1; // RQ3
				tx_byte_reg  <= echo_byte_reg;
			end else if (send_tilde) begin
				tx_start_reg <= 1'b1; // RQ11
				tx_byte_reg  <= CH_TILDE;
			end else if (send_rx) begin
				tx_start_reg <= 1'b1;
				tx_byte_reg  <= rx_mem[rd_ptr_reg[RX_AW-1:0]];
			end
		end
	end

	// One-byte hold; the radio core must drain it within a character.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_valid_reg <= 1'b0;
			radio_tx_data  <= 8'h00;
		end else if (host_data) begin
			hold_valid_reg <= 1'b1;
			radio_tx_data  <= rx_data;
		end else if (radio_tx_valid && radio_tx_ready) begin
			hold_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (rx_accept) begin
			rx_mem[wr_ptr_reg[RX_AW-1:0]] <= radio_rx_data;
		end
	end

	// Status is only a data-waiting flag, never a stop-sending signal.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			status_reg <= 1'b0;
		end else begin
			status_reg <= ~rx_empty; // RQ17 RQ19 RQ21
			if (rx_flush) begin
				rd_ptr_reg <= wr_ptr_reg; // RQ22
			end else begin
				if (rx_accept) begin
					wr_ptr_reg <= wr_ptr_reg + 1'b1;
				end
				if (send_rx) begin
					rd_ptr_reg <= rd_ptr_reg + 1'b1;
				end
			end
		end
	end

	wire [TONE_CNT_W-1:0] half_cnt = (tone_reg == TONE_LOW)
		? TONE_CNT_W'(LOW_HALF - 1) : TONE_CNT_W'(HIGH_HALF - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn || tone_reg == TONE_OFF) begin
			tone_cnt_reg <= '0;
			tone_sq_reg  <= 1'b0;
		end else if (tone_cnt_reg >= half_cnt) begin
			tone_cnt_reg <= '0;
			tone_sq_reg  <= ~tone_sq_reg; // RQ12
		end else begin
			tone_cnt_reg <= tone_cnt_reg + 1'b1;
		end
	end

	assign tx_key = (tone_reg != TONE_OFF); // RQ12
	assign tx_mod = (tone_reg == TONE_LOW || tone_reg == TONE_HIGH)
		& tone_sq_reg;
endmodule : scci_device

// *** hw/scci_pkg.sv ***
// Constants, encodings and the register map shared by both link ends.
// Assumes one 200 MHz clock and a synchronous active-low reset everywhere.
//
// What this block does
// [RQ1] Program pin low makes serial characters commands.
// [RQ2] Setup mode disables the radio link.
// [RQ3] Setup mode echoes every character.
// [RQ4] Only recognised command lines change anything.
// [RQ5] Node command digit 0-7 sets node address.
// [RQ6] Slot command digit 0-4 selects radio channel.
// [RQ7] Exchange data only with matching node and slot.
// [RQ8] Current node and slot live in volatile flops.
// [RQ9] Power-up loads nonvolatile defaults, shipped as zero.
// [RQ10] Save command writes node and slot to storage.
// [RQ11] Finished storage write answers with a tilde.
// [RQ12] Diagnostic commands select carrier, 8 kHz, 16 kHz, off.
// [RQ13] Carriage return terminates and executes each command.
// [RQ14] Program pin high resumes transparent data operation.
// [RQ15] Frames are start, eight data, stop, 9600 baud.
// [RQ16] Back-to-back characters need no pause.
// [RQ17] Status output is no stop-sending flow control.
// [RQ18] Host drains received data before sending more.
// [RQ19] Status rises on the first accepted radio reception into an empty buffer.
// [RQ20] Device active only while enable is low.
// [RQ21] Status high exactly while receive buffer holds data.
// [RQ22] Accepted host data discards held received data.
// [RQ23] Line buffer clears after every carriage return.
package scci_pkg;
	localparam int CLK_HZ           = 200_000_000;
	localparam int BAUD_RATE        = 9600;
	localparam int BIT_CYCLES       = CLK_HZ / BAUD_RATE;
	localparam int LOW_TONE_HZ      = 8000;
	localparam int HIGH_TONE_HZ     = 16000;
	localparam int LOW_HALF_CYCLES  = CLK_HZ / (2 * LOW_TONE_HZ);
	localparam int HIGH_HALF_CYCLES = CLK_HZ / (2 * HIGH_TONE_HZ);
	localparam int BAUD_CNT_W       = 15;
	localparam int TONE_CNT_W       = 14;

	localparam int NODE_W = 3;
	localparam int SLOT_W = 3;
	localparam int RX_AW  = 5;
	localparam int RX_DEPTH = 32;

	localparam logic [7:0] CH_CR        = 8'h0D;
	localparam logic [7:0] CH_TILDE     = 8'h7E;
	localparam logic [7:0] CH_HASH      = 8'h23;
	localparam logic [7:0] CH_ZERO      = 8'h30;
	localparam logic [7:0] CH_NODE_MAX  = 8'h37;
	localparam logic [7:0] CH_SLOT_MAX  = 8'h34;
	localparam logic [31:0] NODE_PREFIX = 32'h41444452;
	localparam logic [31:0] SLOT_PREFIX = 32'h4348414E;
	localparam logic [79:0] SAVE_TEXT   = 80'h53455450524F4752414D;
	localparam logic [47:0] CARRIER_TEXT = 48'h4E4F544F4E45;
	localparam logic [47:0] LOW_TEXT     = 48'h4C46544F4E45;
	localparam logic [47:0] HIGH_TEXT    = 48'h4846544F4E45;

	localparam logic [3:0] LEN_NODE  = 4'h5;
	localparam logic [3:0] LEN_TONE  = 4'h6;
	localparam logic [3:0] LEN_SAVE  = 4'hA;
	localparam logic [3:0] LEN_HASH  = 4'h1;
	localparam logic [3:0] LEN_SAT   = 4'hB;

	localparam int AXI_AW = 4;
	localparam logic [AXI_AW-1:0] REG_CTRL   = 4'h0;
	localparam logic [AXI_AW-1:0] REG_TXDATA = 4'h4;
	localparam logic [AXI_AW-1:0] REG_RXDATA = 4'h8;
	localparam logic [AXI_AW-1:0] REG_STATUS = 4'hC;
	localparam int CTRL_PROG_BIT   = 0;
	localparam int CTRL_EN_BIT     = 1;
	localparam int RXDATA_VALID_BIT = 8;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TONE_OFF,
		TONE_CARRIER,
		TONE_LOW,
		TONE_HIGH
	} scci_tone_t;
endpackage : scci_pkg

// *** hw/scci_link_if.sv ***
// Pin-level link between the host controller and the modem device.
// Assumes both ends are instantiated by the bench on one shared clock.
`timescale 1ns/10ps
interface scci_link_if;
	logic host_txd;
	logic dev_rxd;
	logic setup_n;
	logic enable_n;
	logic status;

	modport device (
		input  host_txd,
		input  setup_n,
		input  enable_n,
		output dev_rxd,
		output status
	);
	modport host (
		output host_txd,
		output setup_n,
		output enable_n,
		input  dev_rxd,
		input  status
	);
endinterface : scci_link_if

// *** hw/scci_uart.sv ***
// Serial character engine: one start, eight data, one stop bit.
// Assumes the rx pin is asynchronous; it is filtered through three flops.
`timescale 1ns/10ps
module scci_uart
	import scci_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYCLES
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       rx_pin,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       tx_start,
	input  wire logic [7:0] tx_data,
	output logic            tx_busy,
	output logic            tx_pin
);
	localparam logic [BAUD_CNT_W-1:0] FULL = BAUD_CNT_W'(BIT_CYC - 1);
	localparam logic [BAUD_CNT_W-1:0] HALF = BAUD_CNT_W'(BIT_CYC / 2);

	logic [2:0]            sync_reg;
	logic                  line_reg;
	logic                  rx_busy_reg;
	logic [BAUD_CNT_W-1:0] rx_cnt_reg;
	logic [3:0]            rx_bit_reg;
	logic [7:0]            rx_shift_reg;
	logic [BAUD_CNT_W-1:0] tx_cnt_reg;
	logic [3:0]            tx_left_reg;
	logic [8:0]            tx_frame_reg;

	// Stop is checked mid-bit, so back-to-back frames are caught. RQ16
	always_ff @(posedge aclk) begin
		rx_valid <= 1'b0;
		if (!aresetn) begin
			sync_reg     <= 3'h7;
			line_reg     <= 1'b1;
			rx_busy_reg  <= 1'b0;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 8'h00;
			rx_data      <= 8'h00;
		end else begin
			sync_reg <= {sync_reg[1:0], rx_pin};
			if (sync_reg[1] == sync_reg[2]) begin
				line_reg <= sync_reg[2];
			end
			if (!rx_busy_reg) begin
				if (!line_reg) begin
					rx_busy_reg <= 1'b1;
					rx_cnt_reg  <= HALF;
					rx_bit_reg  <= 4'h0;
				end
			end else if (rx_cnt_reg != '0) begin
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end else begin
				rx_cnt_reg <= FULL;
				rx_bit_reg <= rx_bit_reg + 4'h1;
				if (rx_bit_reg == 4'h0 && line_reg) begin
					rx_busy_reg <= 1'b0;
				end else if (rx_bit_reg == 4'h9) begin
					rx_busy_reg <= 1'b0;
					rx_valid    <= line_reg; // RQ15
					rx_data     <= rx_shift_reg;
				end else if (rx_bit_reg != 4'h0) begin
					rx_shift_reg <= {line_reg, rx_shift_reg[7:1]};
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy      <= 1'b0;
			tx_pin       <= 1'b1;
			tx_cnt_reg   <= '0;
			tx_left_reg  <= 4'h0;
			tx_frame_reg <= 9'h1FF;
		end else if (!tx_busy) begin
			if (tx_start) begin
				tx_busy      <= 1'b1;
				tx_pin       <= 1'b0;
				tx_cnt_reg   <= FULL;
				tx_left_reg  <= 4'h9;
				tx_frame_reg <= {1'b1, tx_data};
			end
		end else if (tx_cnt_reg != '0) begin
			tx_cnt_reg <= tx_cnt_reg - 1'b1;
		end else if (tx_left_reg == 4'h0) begin
			tx_busy <= 1'b0;
		end else begin
			tx_pin       <= tx_frame_reg[0];
			tx_frame_reg <= {1'b1, tx_frame_reg[8:1]};
			tx_left_reg  <= tx_left_reg - 4'h1;
			tx_cnt_reg   <= FULL;
		end
	end
endmodule : scci_uart

// *** hw/scci_host.sv ***
// Host controller end: AXI4-Lite register slave driving the modem pins.
// Assumes software polls status and drains received bytes before sending.
`timescale 1ns/10ps
module scci_host
	import scci_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYCLES
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	scci_link_if.host              link
);
	logic              aw_got_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic              w_got_reg;
	logic [7:0]        w_byte_reg;
	logic              w_lane_reg;
	logic [1:0]        ctrl_reg;
	logic              tx_start_reg;
	logic [7:0]        tx_byte_reg;
	logic              tx_busy;
	logic              rx_valid;
	logic [7:0]        rx_data;
	logic              rx_full_reg;
	logic [7:0]        rx_byte_reg;
	logic [2:0]        stat_sync_reg;
	logic              stat_q_reg;

	scci_uart #(
		.BIT_CYC(BIT_CYC)
	) u_uart (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rx_pin  (link.dev_rxd),
		.rx_valid(rx_valid),
		.rx_data (rx_data),
		.tx_start(tx_start_reg),
		.tx_data (tx_byte_reg),
		.tx_busy (tx_busy),
		.tx_pin  (link.host_txd)
	);

	assign link.setup_n  = ~ctrl_reg[CTRL_PROG_BIT]; // RQ1
	assign link.enable_n = ~ctrl_reg[CTRL_EN_BIT]; // RQ20

	assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	wire wr_fire  = aw_got_reg & w_got_reg & ~s_axi_bvalid;
	wire wr_ctrl  = wr_fire & w_lane_reg & (aw_addr_reg == REG_CTRL);
	wire wr_tx    = wr_fire & w_lane_reg & (aw_addr_reg == REG_TXDATA);
	wire wr_known = (aw_addr_reg[1:0] == 2'h0);
	wire rd_fire  = s_axi_arvalid & s_axi_arready;
	wire rd_rx    = rd_fire & (s_axi_araddr == REG_RXDATA);
	wire tx_idle  = ~tx_busy & ~tx_start_reg;
	wire [31:0] rd_word =
		(s_axi_araddr == REG_CTRL)   ? {30'h0, ctrl_reg} :
		(s_axi_araddr == REG_RXDATA) ? {23'h0, rx_full_reg, rx_byte_reg} :
		(s_axi_araddr == REG_STATUS) ?
			{29'h0, rx_full_reg, ~tx_idle, stat_q_reg} : 32'h0;
	wire rd_known = (s_axi_araddr[1:0] == 2'h0);

	always_ff @(posedge aclk) begin
		tx_start_reg <= 1'b0;
		if (!aresetn) begin
			aw_got_reg   <= 1'b0;
			aw_addr_reg  <= '0;
			w_got_reg    <= 1'b0;
			w_byte_reg   <= 8'h00;
			w_lane_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
			ctrl_reg     <= CTRL_RST;
			tx_byte_reg  <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg  <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg  <= 1'b1;
				w_byte_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_ctrl) begin
				ctrl_reg <= w_byte_reg[1:0];
			end
			// A byte written while the sender is busy is dropped.
			if (wr_tx && tx_idle) begin
				tx_start_reg <= 1'b1; // RQ15
				tx_byte_reg  <= w_byte_reg;
			end
		end
	end

	// A byte landing as its flag is read keeps the flag set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
			rx_full_reg   <= 1'b0;
			rx_byte_reg   <= 8'h00;
			stat_sync_reg <= 3'h0;
			stat_q_reg    <= 1'b0;
		end else begin
			stat_sync_reg <= {stat_sync_reg[1:0], link.status};
			if (stat_sync_reg[1] == stat_sync_reg[2]) begin
				stat_q_reg <= stat_sync_reg[2]; // RQ18
			end
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rx_valid) begin
				rx_full_reg <= 1'b1;
				rx_byte_reg <= rx_data;
			end else if (rd_rx) begin
				rx_full_reg <= 1'b0;
			end
		end
	end
endmodule : scci_host

// *** testbench/scci_link_sva.sv ***
// Assertions on the serial link joining the host and modem ends.
// Assumes one clock and the same bit length on both ends.
`timescale 1ns/10ps
module scci_link_sva #(
	parameter int BIT_CYC = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic host_txd,
	input wire logic dev_rxd,
	input wire logic setup_n,
	input wire logic enable_n,
	input wire logic status
);
	logic [7:0] dlo_reg, hlo_reg, idl_reg, off_reg, cfg_reg;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Idle, off and setup counters saturate; idle spans never wrap.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{dlo_reg, hlo_reg, idl_reg, off_reg, cfg_reg} <= 40'h0;
		end else begin
			dlo_reg <= dev_rxd ? 8'h00 : dlo_reg + 8'h01;
			hlo_reg <= host_txd ? 8'h00 : hlo_reg + 8'h01;
			idl_reg <= !host_txd ? 8'h00 : idl_reg + {7'h00, ~&idl_reg};
			off_reg <= !enable_n ? 8'h00 : off_reg + {7'h00, ~&off_reg};
			cfg_reg <= setup_n | enable_n ? 8'h00 : cfg_reg + {7'h00, ~&cfg_reg};
		end
	end
	reset_idle_a: assert property ($rose(aresetn) |-> host_txd && dev_rxd
		&& !status && setup_n && enable_n) else $error("link busy after reset");
	dev_bit_a: assert property ($rose(dev_rxd) |-> dlo_reg % BIT_CYC == 0)
		else $error("dev bit len");
	dev_stop_a: assert property (dlo_reg <= 9 * BIT_CYC)
		else $error("dev no stop");
	host_bit_a: assert property ($rose(host_txd) |-> hlo_reg % BIT_CYC == 0)
		else $error("host bit len");
	host_stop_a: assert property (hlo_reg <= 9 * BIT_CYC)
		else $error("host no stop");
	cfg_quiet_a: assert property (cfg_reg > 8'd10 |-> !status)
		else $error("status set in setup mode");
	off_quiet_a: assert property (off_reg > 8'd10 |-> !status)
		else $error("status set while disabled");
	off_idle_a: assert property (off_reg > 8'd199 |-> dev_rxd)
		else $error("serial out busy while disabled");
	echo_a: assert property (cfg_reg > 8'd10 && idl_reg > 8'd150
		&& $fell(host_txd) |-> ##[140:250] !dev_rxd) else $error("no echo");
	cover property ($fell(dev_rxd) && cfg_reg > 8'd10);
	cover property ($rose(status));
	cover property (off_reg > 8'd199);
endmodule : scci_link_sva

// *** testbench/tb_top.sv ***
// Bench: host controller and modem ends joined by the serial link.
// Assumes package, interface, ends and checker compile first.
`timescale 1ns/10ps
module tb_top
	import scci_pkg::*;
;
	localparam int BC = 16;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, radio_tx_valid, radio_tx_ready;
	logic radio_rx_valid, nv_wr_req, nv_wr_done, tx_key, tx_mod, cfg_mode;
	logic [2:0] node_id, radio_slot, radio_rx_node, radio_rx_slot, d;
	logic [2:0] nv_wr_node, nv_wr_slot;
	logic [7:0] radio_tx_data, radio_rx_data, rb [3];
	logic [5:0] saved;
	logic pm;
	int num_errors, checks_done, saves, cnt, seed = 74302;
	logic [47:0] tt [4] = '{CARRIER_TEXT, LOW_TEXT, HIGH_TEXT, 48'(CH_HASH)};
	int tg [4] = '{0, 8, 16, 0};
	always #2.5 aclk = ~aclk;
	scci_link_if scci_link_if_inst ();
	scci_host #(.BIT_CYC(BC)) scci_host_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.link(scci_link_if_inst));
	scci_device #(.BIT_CYC(BC), .LOW_HALF(8), .HIGH_HALF(4)) scci_device_inst (
		.aclk, .aresetn, .link(scci_link_if_inst), .node_id, .radio_slot,
		.radio_tx_valid, .radio_tx_data, .radio_tx_ready, .radio_rx_valid,
		.radio_rx_data, .radio_rx_node, .radio_rx_slot,
		.nv_dflt_node(3'h0), .nv_dflt_slot(3'h0), .nv_wr_req, .nv_wr_node,
		.nv_wr_slot, .nv_wr_done, .tx_key, .tx_mod, .cfg_mode);
	scci_link_sva #(.BIT_CYC(BC)) scci_link_sva_inst (.aclk, .aresetn,
		.host_txd(scci_link_if_inst.host_txd),
		.dev_rxd(scci_link_if_inst.dev_rxd),
		.setup_n(scci_link_if_inst.setup_n),
		.enable_n(scci_link_if_inst.enable_n),
		.status(scci_link_if_inst.status));
	// Store answers one cycle late.
	always @(posedge aclk) begin
		nv_wr_done <= nv_wr_req;
		saves += nv_wr_req;
		if (nv_wr_req)
			saved = {nv_wr_node, nv_wr_slot};
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// Starts one edge late to avoid double assignment.
	task automatic axi(input bit wr, input logic [3:0] a, input logic [31:0] v);
		bit ta, tw, tb;
		int n;
		n = 0;
		tb = 1'b0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, v};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		while (!tb && n < 60) begin
			@(posedge aclk);
			ta = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
			q = s_axi_rdata;
			r = wr ? s_axi_bresp : s_axi_rresp;
			if (ta)
				{s_axi_awvalid, s_axi_arvalid} <= 2'h0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			n++;
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		chk(tb, 1, "bus answer");
	endtask : axi
	task automatic get_char(input logic [7:0] c);
		int n;
		n = 0;
		q = 32'h0;
		while (q[2] !== 1'b1 && n < 400) begin
			axi(0, REG_STATUS, 0);
			n++;
		end
		axi(0, REG_RXDATA, 0);
		chk(q[8:0], {1'b1, c}, "char at host");
	endtask : get_char
	task automatic put_char(input logic [7:0] c, input bit echo);
		axi(1, REG_TXDATA, {24'h0, c});
		if (echo)
			get_char(c);
		else
			repeat (12 * BC) @(posedge aclk);
	endtask : put_char
	task automatic send_line(input logic [79:0] t, input int n);
		for (int i = n - 1; i >= 0; i--)
			put_char(t[8 * i +: 8], 1'b1);
		put_char(CH_CR, 1'b1);
	endtask : send_line
	task automatic rx_byte(input logic [7:0] v, input logic [5:0] ns);
		@(posedge aclk);
		{radio_rx_valid, radio_rx_data, radio_rx_node, radio_rx_slot} <=
			{1'b1, v, ns};
		@(posedge aclk);
		radio_rx_valid <= 1'b0;
	endtask : rx_byte
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, radio_rx_valid, radio_tx_ready} = 3'h1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		{radio_rx_data, radio_rx_node, radio_rx_slot} = 14'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axi(0, REG_CTRL, 0);
		chk(q[1:0], CTRL_RST, "ctrl reset");
		axi(0, 4'h2, 0);
		chk(r, RESP_SLVERR, "unaligned read");
		chk({node_id, radio_slot}, 0, "defaults");
		repeat (210) @(posedge aclk);
		axi(1, REG_CTRL, 3);
		repeat (4) @(posedge aclk);
		chk(cfg_mode, 1, "config entry");
		d = 3'h1 + 3'($unsigned($random(seed)) % 7);
		send_line({NODE_PREFIX, CH_ZERO + 8'(d)}, 5);
		chk(node_id, d, "node set");
		send_line({SLOT_PREFIX, 8'h35}, 5);
		send_line({32'h6368616E, 8'h31}, 5);
		chk(radio_slot, 0, "stray line");
		send_line({SLOT_PREFIX, CH_SLOT_MAX}, 5);
		chk(radio_slot, 4, "slot set");
		send_line(SAVE_TEXT, 10);
		get_char(CH_TILDE);
		chk({saves[5:0], saved}, {6'h1, d, 3'h4}, "saved");
		rx_byte(8'h5A, {d, 3'h4});
		repeat (8) @(posedge aclk);
		chk(scci_link_if_inst.status, 0, "radio in setup");
		foreach (tt[i]) begin
			send_line(80'(tt[i]), i < 3 ? 6 : 1);
			pm = tx_mod;
			cnt = 0;
			repeat (64) begin
				@(posedge aclk);
				cnt += (tx_mod !== pm);
				pm = tx_mod;
			end
			chk({tx_key, 8'(cnt)}, {i < 3, 8'(tg[i])}, "tone");
		end
		axi(1, REG_CTRL, 2);
		repeat (4) @(posedge aclk);
		chk(cfg_mode, 0, "config exit");
		rx_byte(8'hA5, {d + 3'h1, 3'h4});
		repeat (40) @(posedge aclk);
		chk(scci_link_if_inst.status, 0, "foreign node");
		foreach (rb[k]) begin
			rb[k] = 8'($random(seed));
			rx_byte(rb[k], {d, 3'h4});
		end
		chk(scci_link_if_inst.status, 1, "buffer held");
		foreach (rb[k])
			get_char(rb[k]);
		chk(scci_link_if_inst.status, 0, "buffer empty");
		rx_byte(8'h11, {d, 3'h4});
		rx_byte(8'h22, {d, 3'h4});
		radio_tx_ready <= 1'b0;
		put_char(8'hC3, 1'b0);
		chk({radio_tx_valid, radio_tx_data}, 9'h1C3, "radio send");
		chk(scci_link_if_inst.status, 0, "rx flushed");
		radio_tx_ready <= 1'b1;
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(node_id, 0, "node after reset");
		wrap_up();
	end
	initial begin
		repeat (60000) @(posedge aclk);
		num_errors++;
		wrap_up();
	end
endmodule : tb_top
